// file: hw/clbp_pkg.sv
package clbp_pkg;

  // Register offsets within the host function's memory base
  localparam logic [7:0]  CTRL_CUR_OFFSET   = 8'h24;
  localparam logic [7:0]  BULK_HEAD_OFFSET  = 8'h28;

  // Descriptor address field of each pointer register
  localparam int          ADDR_LSB          = 4;
  localparam int          ADDR_MSB          = 31;
  localparam int          ADDR_WIDTH        = 28;

  // Reset values
  localparam logic [31:0] CTRL_CUR_RESET    = 32'h0000_0000;
  localparam logic [31:0] BULK_HEAD_RESET   = 32'h0000_0000;

  // Field positions in neighbouring registers
  localparam int          LIST_FILLED_BIT   = 1;
  localparam int          CTRL_ENABLE_BIT   = 4;

  // List end marker
  localparam logic [27:0] LIST_END          = 28'h000_0000;

endpackage : clbp_pkg

// file: hw/clbp_pointers.sv
`timescale 1ns/1ps

module clbp_pointers
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Register access from the function's memory base
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_hit,
  // Neighbouring register fields
  input  wire logic [31:0] host_control_reg,
  input  wire logic [31:0] command_status_reg,
  input  wire logic [31:0] control_head_pointer,
  // List-processing engine events
  input  wire logic        frame_start,
  input  wire logic        ctrl_ed_done,
  input  wire logic [27:0] ctrl_next_addr,
  input  wire logic        ctrl_list_end,
  input  wire logic        bulk_list_start,
  input  wire logic        init_load,
  input  wire logic [27:0] host_comm_area_bulk,
  // To the list-processing engine
  output logic      [27:0] control_current_addr,
  output logic      [27:0] bulk_head_addr,
  output logic      [27:0] ctrl_walk_addr,
  output logic      [27:0] bulk_walk_addr,
  output logic             ctrl_walk_valid,
  output logic             control_list_filled_clr
);

  // Overview of the block:
  // Two pointer registers sit here. The control current pointer belongs to
  // the list engine while the control list runs, and to software only while
  // the list is switched off. The bulk head pointer is loaded by software or
  // by the engine's initial fetch from the host communication area.
  // Only the descriptor address field is stored; the reserved nibble is
  // rebuilt as zero on every read, which saves flops and keeps stray bits
  // written by software from ever showing up again.
  // Every engine strobe is a one-cycle pulse taken at the rising edge, except frame_start, which gates the walk valid directly,
  // ctrl_list_end, which also gates the flag clear pulse directly, and bulk_list_start, which is unused;
  // more than one pulse in the same cycle is resolved by a fixed priority.

  // Stored pointer fields, bits 31..4 of each register
  logic [27:0] ctrl_cur_ff;
  logic [27:0] nxt_ctrl_cur;
  logic [27:0] bulk_head_ff;
  logic [27:0] nxt_bulk_head;

  // Read data register and its next value; it stands until the next read
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  // Address decode of the two pointer registers
  wire logic sel_ctrl_cur  = (reg_addr == clbp_pkg::CTRL_CUR_OFFSET);
  wire logic sel_bulk_head = (reg_addr == clbp_pkg::BULK_HEAD_OFFSET);
  wire logic sel_none      = !sel_ctrl_cur && !sel_bulk_head;

  // Read strobes split per register
  wire logic rd_ctrl_cur  = reg_rd && sel_ctrl_cur;
  wire logic rd_bulk_head = reg_rd && sel_bulk_head;
  wire logic rd_unmapped  = reg_rd && sel_none;

  // Neighbouring flags, owned by other registers of the host function
  wire logic control_list_filled = command_status_reg[clbp_pkg::LIST_FILLED_BIT];
  wire logic control_list_enable = host_control_reg[clbp_pkg::CTRL_ENABLE_BIT];

  // Address fields of the neighbouring head register and of the write data
  wire logic [27:0] ctrl_head_addr =
    control_head_pointer[clbp_pkg::ADDR_MSB:clbp_pkg::ADDR_LSB];
  wire logic [27:0] wr_addr_field =
    reg_wdata[clbp_pkg::ADDR_MSB:clbp_pkg::ADDR_LSB];

  // Software may write the current pointer only while the list is off;
  // a write with the list on is dropped so the engine's value survives a
  // careless driver. Reads are never blocked and give a momentary value.
  wire logic sw_ctrl_wr = reg_wr && sel_ctrl_cur && !control_list_enable;
  wire logic sw_bulk_wr = reg_wr && sel_bulk_head;

  // End-of-list decisions, taken on the filled flag as it stands
  wire logic ctrl_reload = ctrl_list_end && control_list_filled;
  wire logic ctrl_hold   = ctrl_list_end && !control_list_filled;

  // Lower-priority control pointer sources, masked by the end of the list
  wire logic ctrl_step    = ctrl_ed_done && !ctrl_list_end;
  wire logic ctrl_sw_load = sw_ctrl_wr && !ctrl_list_end && !ctrl_ed_done;

  // Bulk head sources; the initial load wins over a racing software write,
  // since the fetch from system memory is the value the engine relies on.
  wire logic bulk_init    = init_load;
  wire logic bulk_sw_load = sw_bulk_wr && !init_load;

  // Current pointer is live while it holds a descriptor address
  wire logic ctrl_cur_live = (ctrl_cur_ff != clbp_pkg::LIST_END);

  // Read words with the reserved nibble forced to zero
  wire logic [31:0] rd_word_ctrl = {ctrl_cur_ff, 4'h0};
  wire logic [31:0] rd_word_bulk = {bulk_head_ff, 4'h0};

  // Next control current pointer. Engine events win over software writes:
  // the engine owns the pointer while the list runs, and a write can only
  // land while the list is off, when the engine raises no events.
  // Limitation: a filled flag set in the very cycle of the end pulse is
  // seen; one set a cycle later waits for the next end of the list.
  always_comb
  begin
    nxt_ctrl_cur = ctrl_cur_ff;
    if (ctrl_reload)
    begin
      nxt_ctrl_cur = ctrl_head_addr;
    end
    else if (ctrl_hold)
    begin
      nxt_ctrl_cur = ctrl_cur_ff;
    end
    else if (ctrl_step)
    begin
      nxt_ctrl_cur = ctrl_next_addr;
    end
    else if (ctrl_sw_load)
    begin
      nxt_ctrl_cur = wr_addr_field;
    end
  end

  // Next bulk head pointer; reserved low bits are not stored
  always_comb
  begin
    nxt_bulk_head = bulk_head_ff;
    if (bulk_init)
    begin
      nxt_bulk_head = host_comm_area_bulk;
    end
    else if (bulk_sw_load)
    begin
      nxt_bulk_head = wr_addr_field;
    end
  end

  // Read data is registered so the bus sees a stable word for as long as
  // it likes; unmapped offsets read zero rather than stale data.
  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (rd_ctrl_cur)
    begin
      nxt_rdata = rd_word_ctrl;
    end
    else if (rd_bulk_head)
    begin
      nxt_rdata = rd_word_bulk;
    end
    else if (rd_unmapped)
    begin
      nxt_rdata = 32'h0000_0000;
    end
  end

  // Control current pointer; zero after reset marks the end of the list
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ctrl_cur_ff <= clbp_pkg::CTRL_CUR_RESET[clbp_pkg::ADDR_MSB:clbp_pkg::ADDR_LSB];
    end
    else
    begin
      ctrl_cur_ff <= nxt_ctrl_cur;
    end
  end

  // Bulk head pointer
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      bulk_head_ff <= clbp_pkg::BULK_HEAD_RESET[clbp_pkg::ADDR_MSB:clbp_pkg::ADDR_LSB];
    end
    else
    begin
      bulk_head_ff <= nxt_bulk_head;
    end
  end

  // Read data register
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Register access outputs; the hit flag is combinational so the bus can
  // claim the access in the same cycle as the address appears.
  assign reg_rdata = rdata_ff;
  assign reg_hit   = !sel_none;

  // Pointers seen by the engine, straight from the flops
  assign control_current_addr = ctrl_cur_ff;
  assign bulk_head_addr       = bulk_head_ff;

  // Frame walk resumes at the current pointer; zero means the list is
  // exhausted, so the walk valid stays low and the head address is offered. The choice is a
  // plain mux so the engine sees the new pointer one cycle after an update.
  assign ctrl_walk_valid = frame_start && ctrl_cur_live;
  assign ctrl_walk_addr  = ctrl_cur_live ? ctrl_cur_ff : ctrl_head_addr;
  assign bulk_walk_addr  = bulk_head_ff;

  // Flag clear pulse to the command status register owner; that owner
  // clears the bit, so a set by software in the same cycle is its call.
  assign control_list_filled_clr = ctrl_reload;

  // Traversal start is qualified by the engine; the bulk walk always
  // starts from the head register, so this pulse needs no logic here.
  wire logic unused_bulk_start = bulk_list_start;

endmodule : clbp_pointers

// file: tb/clbp_host_model.sv
`timescale 1ns/1ps
module clbp_host_model
(
  // Driver side
  input  wire logic        h_wr, rogue, cle,
  input  wire logic [7:0]  h_addr,
  input  wire logic [31:0] h_data,
  // Register side
  output logic             reg_wr,
  output logic      [31:0] reg_wdata
);
  // Running list's pointer is only read; rogue breaks this on purpose
  assign reg_wr    = h_wr && (rogue || !(cle && h_addr == 8'h24));
  // Low bits always sent as zero
  assign reg_wdata = {h_data[31:4], 4'h0};
endmodule : clbp_host_model

// file: tb/clbp_pointers_monitor.sv
`timescale 1ns/1ps
module clbp_pointers_monitor
(
  // Watched ports
  input wire logic clock, rst_n, reg_rd, reg_hit, ctrl_ed_done, ctrl_list_end,
  input wire logic init_load, control_list_filled_clr,
  input wire logic reg_wr, frame_start, ctrl_walk_valid,
  input wire logic [31:0] host_control_reg,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_rdata, command_status_reg, control_head_pointer,
  input wire logic [27:0] ctrl_next_addr, host_comm_area_bulk, control_current_addr,
  input wire logic [27:0] bulk_head_addr, ctrl_walk_addr
);
  // One domain, quiet in reset
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_end_set;
    ctrl_list_end && command_status_reg[1];
  endsequence
  a_hit_decode: assert property (reg_hit == (reg_addr == 8'h24 || reg_addr == 8'h28))
    else $error("decode");
  a_ed_step: assert property (ctrl_ed_done && !ctrl_list_end |=>
    control_current_addr == $past(ctrl_next_addr)) else $error("step");
  a_end_reload: assert property (s_end_set |-> control_list_filled_clr ##1
    control_current_addr == $past(control_head_pointer[31:4])) else $error("reload");
  a_end_hold: assert property (ctrl_list_end && !command_status_reg[1] |->
    !control_list_filled_clr ##1 $stable(control_current_addr)) else $error("hold");
  a_init_load: assert property (init_load |=>
    bulk_head_addr == $past(host_comm_area_bulk)) else $error("init");
  a_walk_resume: assert property (control_current_addr != 28'h0 |->
    ctrl_walk_addr == control_current_addr) else $error("resume");
  a_walk_head: assert property (control_current_addr == 28'h0 |->
    ctrl_walk_addr == control_head_pointer[31:4]) else $error("head");
  a_read_bulk: assert property (reg_rd && reg_addr == 8'h28 |=>
    reg_rdata == {$past(bulk_head_addr), 4'h0}) else $error("read");
  a_read_ctrl: assert property (reg_rd && reg_addr == 8'h24 |=>
    reg_rdata == {$past(control_current_addr), 4'h0}) else $error("read ctrl");
  a_ctrl_lock: assert property (reg_wr && reg_addr == 8'h24 && host_control_reg[4] &&
    !ctrl_list_end && !ctrl_ed_done |=> $stable(control_current_addr)) else $error("lock");
  a_walk_valid: assert property (ctrl_walk_valid ==
    (frame_start && control_current_addr != 28'h0)) else $error("valid");
endmodule : clbp_pointers_monitor

// file: tb/clbp_pointers_tb.sv
`timescale 1ns/1ps
module clbp_pointers_tb;
  // Bench drives, uut answers
  logic        clock = 0, rst_n = 0, hw = 0, rd = 0, rg = 0, fs = 0, ed = 0, le = 0, il = 0;
  logic        wr, clr, wv;
  logic [7:0]  ad = 8'h00;
  logic [31:0] hd = 0, wd, rq, hc = 0, cs = 0, hp = 32'h1357_9BD0, d;
  logic [27:0] nx = 0, ha = 0, cur, bh, bw, wa;
  int          bad_count = 0, compares = 0, seed = 42560, cyc = 0;
  clbp_host_model drv (.h_wr(hw), .rogue(rg), .cle(hc[4]), .h_addr(ad), .h_data(hd),
    .reg_wr(wr), .reg_wdata(wd));
  clbp_pointers uut (.clock, .rst_n, .reg_addr(ad), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd),
    .reg_rdata(rq), .reg_hit(), .host_control_reg(hc), .command_status_reg(cs),
    .control_head_pointer(hp), .frame_start(fs), .ctrl_ed_done(ed), .ctrl_next_addr(nx),
    .ctrl_list_end(le), .bulk_list_start(1'b0), .init_load(il), .host_comm_area_bulk(ha),
    .control_current_addr(cur), .bulk_head_addr(bh), .ctrl_walk_addr(wa), .bulk_walk_addr(bw),
    .ctrl_walk_valid(wv), .control_list_filled_clr(clr));
  // Clock, and a ceiling well above the run's length
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) if (++cyc > 600) begin bad_count++; conclude(); end
  task chk(input logic [31:0] s, e);
    compares++;
    if (s !== e) begin bad_count++; $display("MISMATCH %0t got %h want %h", $time, s, e); end
  endtask : chk
  // Expected read word: reserved nibble reads zero
  function automatic logic [31:0] exp_rd(input logic [31:0] v);
    return {v[31:4], 4'h0};
  endfunction : exp_rd
  // One strobe cycle per access, then one idle cycle; read data stands after it
  task acc(input logic w, input logic [7:0] a, input logic [31:0] v);
    {hw, rd, ad, hd} = {w, !w, a, v};
    @(negedge clock);
    {hw, rd} = 2'h0;
    @(negedge clock);
  endtask : acc
  task conclude;
    $display("bad_count %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // Reset, then random words through every pointer path
  initial begin
    repeat (16) @(negedge clock);
    rst_n = 1;
    acc(0, 8'h24, 0); chk(rq, 0);
    chk(wa, 28'h1357_9BD);
    repeat (6) begin
      d = $random(seed); hc = 0; fs = d[0];
      acc(1, 8'h28, d); acc(0, 8'h28, 0); chk(rq, exp_rd(d));
      chk(bw, d[31:4]);
      nx = d[31:4]; ed = 1; @(negedge clock); ed = 0; chk(cur, nx);
      chk(wa, nx != 0 ? nx : hp[31:4]); chk(wv, fs && nx != 0);
      hp = ~d; cs = 32'h2; le = 1; #1 chk(clr, 1);
      @(negedge clock); cs = 0; chk(cur, hp[31:4]);
      @(negedge clock); le = 0; chk(cur, hp[31:4]);
      hc = 32'h10; rg = d[1]; acc(1, 8'h24, d); rg = 0; chk(cur, hp[31:4]);
      hc = 0; acc(1, 8'h24, d); chk(cur, d[31:4]);
      acc(0, 8'h24, 0); chk(rq, exp_rd(d));
      ha = d[27:0]; il = 1; @(negedge clock); il = 0; chk(bh, ha);
    end
    conclude();
  end
endmodule : clbp_pointers_tb
bind clbp_pointers clbp_pointers_monitor mon (.clock, .rst_n, .reg_rd, .reg_hit, .ctrl_ed_done,
  .reg_wr, .frame_start, .ctrl_walk_valid, .host_control_reg,
  .ctrl_list_end, .init_load, .control_list_filled_clr, .reg_addr, .reg_rdata,
  .command_status_reg, .control_head_pointer, .ctrl_next_addr, .host_comm_area_bulk,
  .control_current_addr, .bulk_head_addr, .ctrl_walk_addr);
